// *** accessory_switch_key_control.sv ***
/*
  Switch sequencing, auto/manual switch selection and remote key classification
  for a mini-USB accessory port, with a plain register port.
  Assumes an external identification flow, ID comparator and 5-bit ID converter.
*/
`timescale 1ns/100ps
// Function
// - Delay enabled at attach: wait programmed time
// - Delay disabled: hold switches until software enables
// - Supported accessory closes its switches automatically
// - Gate low forces every signal switch open
// - Auto select follows identification, incl. jig/boot
// - Manual select takes switches from manual register
// - Gate and select never alter sequence timing
// - Auto-to-manual swaps; back to auto changes nothing
// - Key reporting only for audio type 1
// - Key reporting: convert on key event, set flags
// - No key reporting: periodic conversion, change flag
// - No key reporting: no press flags or buttons
// - Audio closes 4,5,7; isolates OTG and VBUS0
// - Per-type automatic switch sets
// - VBUS and OTG paths follow software bits
// - Detach returns to standby, signal switches, jig and boot open
// - Clamp on while release bit is low
// - Ignore presses under 20 ms, then time
// - Too-short press sets error and short flag
// - Medium press sets short flag and button
// - Long press flag, later release flag
// - Sample ID each wake-up; rising edge detaches
module accessory_switch_key_control #(
  parameter int unsigned MS_CYCLES_P = accessory_switch_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port
  input wire logic [accessory_switch_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [accessory_switch_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [accessory_switch_pkg::DATA_W-1:0] reg_rdata_out,
  // Identification and ID line
  input wire logic id_done_in,
  input wire accessory_switch_pkg::device_type_type device_type_in,
  input wire logic id_open_sense_in,
  input wire logic key_press_in,
  input wire logic adc_done_in,
  input wire logic [accessory_switch_pkg::ADC_W-1:0] adc_result_in,
  output logic adc_start_out,
  // Switches and pins
  output logic [accessory_switch_pkg::SW_N-1:0] signal_switch_out,
  output logic otg_path_switch_out,
  output logic vbus_path_switch0_out,
  output logic vbus_path_switch1_out,
  output logic clamp_on_out,
  output logic jig_out,
  output logic boot_out,
  output logic event_line_out
);
  import accessory_switch_pkg::*;

  function automatic logic [MS_W-1:0] step_ms(input logic [3:0] code,
                                              input logic [MS_W-1:0] step);
    logic [MS_W-1:0] n;
    n = {{(MS_W-4){1'b0}}, code} + MS_W'(1);
    return MS_W'(n * step);
  endfunction : step_ms

  function automatic logic [SW_N-1:0] auto_mask(input device_type_type t);
    unique case (t)
      DEV_AUDIO1, DEV_TTY: return MASK_AUDIO;
      DEV_USB, DEV_USB_CHG, DEV_JIG_USB: return MASK_USB;
      DEV_UART, DEV_JIG_UART: return MASK_UART;
      default: return MASK_NONE;
    endcase
  endfunction : auto_mask

  function automatic logic [BTN_W-1:0] button_decode(input logic [ADC_W-1:0] r);
    logic [BTN_W-1:0] b;
    b = '0;
    if (r >= BTN_CODE_FIRST && r < BTN_CODE_FIRST + 5'(BTN_COUNT)) begin
      b[4'(r - BTN_CODE_FIRST)] = 1'b1;
    end else begin
      b[BTN_UNKNOWN] = 1'b1;
    end
    return b;
  endfunction : button_decode

  logic [CTL_W-1:0] ctl;
  logic [TIM_W-1:0] timing;
  logic [MAN_W-1:0] manual;
  logic [EV_W-1:0] events;
  logic [BTN_W-1:0] buttons;
  mode_type mode;
  key_state_type key_state;
  key_state_type next_key_state;
  device_type_type type_held;
  logic ms_tick;
  logic delay_armed;
  logic [MS_W-1:0] wait_ms;
  logic [MS_W-1:0] wake_ms;
  logic wake_tick;
  logic id_prev;
  logic detach_evt;
  logic attach_evt;
  logic sel_manual;
  logic auto_prev;
  logic key_mode;
  logic [MS_W-1:0] key_ms;
  logic [ADC_W-1:0] adc_last;
  logic key_start;
  logic err_set;
  logic short_set;
  logic long_set;
  logic rel_set;
  logic press_begin;
  logic adc_chg_set;
  logic rd_events;
  logic rd_button;
  logic [EV_W-1:0] next_events;
  logic [SW_N-1:0] next_switch;
  logic audio_iso;
  logic [BTN_W-1:0] btn_decoded;

  ms_tick_gen #(.CYCLES(MS_CYCLES_P)) u_ms_tick (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .tick_out(ms_tick)
  );

  assign rd_events = reg_read_in && reg_addr_in == REG_EVENTS;
  assign rd_button = reg_read_in && reg_addr_in == REG_BUTTON;
  assign attach_evt = mode == MODE_STANDBY && id_done_in;
  // A function result cannot be part-selected directly
  assign btn_decoded = button_decode(adc_last);

  // Register writes
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctl <= CONTROL_RESET;
      timing <= TIMING_RESET;
      manual <= MANUAL_RESET;
    end else if (reg_write_in) begin
      unique case (reg_addr_in)
        REG_CONTROL: ctl <= reg_wdata_in[CTL_W-1:0];
        REG_TIMING: timing <= reg_wdata_in[TIM_W-1:0];
        REG_MANUAL: manual <= reg_wdata_in[MAN_W-1:0];
        default: ;
      endcase
    end
  end

  // Wake-up interval enable
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wake_ms <= '0;
      wake_tick <= 1'b0;
    end else if (ms_tick && wake_ms + MS_W'(1) >= step_ms(timing[TIM_WAKE_LSB +: 4],
                                                            WAKE_STEP_MS)) begin
      wake_ms <= '0;
      wake_tick <= 1'b1;
    end else begin
      wake_ms <= ms_tick ? wake_ms + MS_W'(1) : wake_ms;
      wake_tick <= 1'b0;
    end
  end

  // ID line sampled only at wake-up; a rising edge ends the session
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      id_prev <= 1'b1;
    end else if (wake_tick) begin
      id_prev <= id_open_sense_in;
    end
  end
  assign detach_evt = mode != MODE_STANDBY && wake_tick && id_open_sense_in && !id_prev;

  // Session sequencing, deliberately blind to gate and select bits
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mode <= MODE_STANDBY;
      wait_ms <= '0;
      delay_armed <= 1'b0;
      type_held <= DEV_NONE;
    end else begin
      unique case (mode)
        MODE_STANDBY: begin
          wait_ms <= '0;
          if (id_done_in) begin
            mode <= MODE_HOLD;
            delay_armed <= ctl[CTL_DELAY_EN];
            type_held <= device_type_in;
          end
        end
        MODE_HOLD: begin
          if (detach_evt) begin
            mode <= MODE_STANDBY;
          end else if (delay_armed) begin
            if (ms_tick) begin
              wait_ms <= wait_ms + MS_W'(1);
              if (wait_ms + MS_W'(1) >= step_ms(timing[TIM_WAIT_LSB +: 4], WAIT_STEP_MS)) begin
                mode <= MODE_ACTIVE;
              end
            end
          end else if (ctl[CTL_DELAY_EN]) begin
            mode <= MODE_ACTIVE;
          end
        end
        MODE_ACTIVE: begin
          if (detach_evt) begin
            mode <= MODE_STANDBY;
          end
        end
        default: mode <= MODE_STANDBY;
      endcase
    end
  end

  // Selection source latched per session
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sel_manual <= 1'b0;
      auto_prev <= 1'b1;
    end else begin
      auto_prev <= ctl[CTL_AUTO];
      if (attach_evt) begin
        sel_manual <= !ctl[CTL_AUTO];
      end else if (mode != MODE_STANDBY && auto_prev && !ctl[CTL_AUTO]) begin
        sel_manual <= 1'b1;
      end
    end
  end

  // Switch outputs
  assign audio_iso = mode != MODE_STANDBY && !sel_manual
                     && (type_held == DEV_AUDIO1 || type_held == DEV_TTY);
  always_comb begin
    next_switch = '0;
    if (mode == MODE_ACTIVE && ctl[CTL_GATE]) begin
      next_switch = sel_manual ? manual[SW_N-1:0] : auto_mask(type_held);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      signal_switch_out <= '0;
      jig_out <= 1'b0;
      boot_out <= 1'b0;
      otg_path_switch_out <= 1'b0;
      vbus_path_switch0_out <= 1'b0;
      vbus_path_switch1_out <= 1'b0;
      clamp_on_out <= 1'b1;
    end else begin
      signal_switch_out <= next_switch;
      jig_out <= mode == MODE_ACTIVE && (sel_manual ? manual[MAN_JIG]
                 : (type_held == DEV_JIG_USB || type_held == DEV_JIG_UART));
      boot_out <= mode == MODE_ACTIVE && (sel_manual ? manual[MAN_BOOT]
                  : type_held == DEV_JIG_UART);
      otg_path_switch_out <= ctl[CTL_OTG_EN] && !audio_iso;
      vbus_path_switch0_out <= !ctl[CTL_VBUS_SEL] && !audio_iso;
      vbus_path_switch1_out <= ctl[CTL_VBUS_SEL];
      clamp_on_out <= !ctl[CTL_CLAMP_REL];
    end
  end

  // Key classification
  assign key_mode = ctl[CTL_KEY_REPORT] && type_held == DEV_AUDIO1
                    && mode != MODE_STANDBY;
  always_comb begin
    next_key_state = key_state;
    key_start = 1'b0;
    err_set = 1'b0;
    short_set = 1'b0;
    long_set = 1'b0;
    rel_set = 1'b0;
    press_begin = 1'b0;
    if (!key_mode) begin
      next_key_state = KEY_IDLE;
    end else begin
      unique case (key_state)
        KEY_IDLE: begin
          if (key_press_in) begin
            next_key_state = KEY_DEBOUNCE;
            press_begin = 1'b1;
          end
        end
        KEY_DEBOUNCE: begin
          if (!key_press_in) begin
            next_key_state = KEY_IDLE;
          end else if (ms_tick && key_ms + MS_W'(1) >= DEBOUNCE_MS) begin
            next_key_state = KEY_HELD;
            key_start = 1'b1;
          end
        end
        KEY_HELD: begin
          if (!key_press_in) begin
            next_key_state = KEY_IDLE;
            short_set = 1'b1;
            err_set = key_ms < step_ms(timing[TIM_SHORT_LSB +: 4], SHORT_STEP_MS);
          end else if (ms_tick && key_ms + MS_W'(1)
                       >= step_ms(timing[TIM_LONG_LSB +: 4], LONG_STEP_MS)) begin
            next_key_state = KEY_LONG;
            long_set = 1'b1;
          end
        end
        KEY_LONG: begin
          if (!key_press_in) begin
            next_key_state = KEY_IDLE;
            rel_set = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      key_state <= KEY_IDLE;
      key_ms <= '0;
    end else begin
      key_state <= next_key_state;
      if (next_key_state != key_state) begin
        key_ms <= '0;
      end else if (ms_tick && key_ms != '1) begin
        key_ms <= key_ms + MS_W'(1);
      end
    end
  end

  // Conversion requests and result history
  assign adc_chg_set = adc_done_in && !key_mode && mode != MODE_STANDBY
                       && adc_result_in != adc_last;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      adc_start_out <= 1'b0;
      adc_last <= '1;
    end else begin
      adc_start_out <= key_start || (mode != MODE_STANDBY && !key_mode && wake_tick);
      if (adc_done_in) begin
        adc_last <= adc_result_in;
      end
    end
  end

  // Event flags: a set in the clearing cycle survives
  always_comb begin
    next_events = rd_events ? '0 : events;
    next_events[EV_ATTACH] = next_events[EV_ATTACH] | attach_evt;
    next_events[EV_DETACH] = next_events[EV_DETACH] | detach_evt;
    next_events[EV_SHORT] = next_events[EV_SHORT] | short_set;
    next_events[EV_LONG] = next_events[EV_LONG] | long_set;
    next_events[EV_LONG_REL] = next_events[EV_LONG_REL] | rel_set;
    next_events[EV_ADC_CHG] = next_events[EV_ADC_CHG] | adc_chg_set;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      events <= '0;
      event_line_out <= 1'b0;
    end else begin
      events <= next_events;
      event_line_out <= |next_events;
    end
  end

  // Button bits; error clears on read or on the next press
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      buttons <= '0;
    end else begin
      if ((short_set && !err_set) || long_set) begin
        buttons[BTN_W-2:0] <= btn_decoded[BTN_W-2:0];
      end
      if (err_set) begin
        buttons[BTN_ERROR] <= 1'b1;
      end else if (rd_button || press_begin) begin
        buttons[BTN_ERROR] <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        REG_CONTROL: reg_rdata_out <= DATA_W'(ctl);
        REG_TIMING: reg_rdata_out <= DATA_W'(timing);
        REG_MANUAL: reg_rdata_out <= DATA_W'({adc_last, 7'h00, manual});
        REG_EVENTS: reg_rdata_out <= DATA_W'(events);
        REG_BUTTON: reg_rdata_out <= DATA_W'(buttons);
        REG_STATUS: reg_rdata_out <= DATA_W'({key_state, sel_manual, type_held, mode,
                                              signal_switch_out});
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_hold_open;
    mode == MODE_HOLD |=> signal_switch_out == '0;
  endproperty
  a_hold_open: assert property (p_hold_open) else $error("switch closed while held");

  property p_delay_close;
    mode == MODE_HOLD && delay_armed && ms_tick
      && wait_ms + MS_W'(1) >= step_ms(timing[TIM_WAIT_LSB +: 4], WAIT_STEP_MS) && !detach_evt
      |=> mode == MODE_ACTIVE;
  endproperty
  a_delay_close: assert property (p_delay_close) else $error("wait expiry missed");

  property p_gate_open;
    !ctl[CTL_GATE] |=> signal_switch_out == '0;
  endproperty
  a_gate_open: assert property (p_gate_open) else $error("switch closed with gate low");

  property p_standby_open;
    mode == MODE_STANDBY |=> signal_switch_out == '0 && !jig_out && !boot_out;
  endproperty
  a_standby_open: assert property (p_standby_open) else $error("switch closed in standby");

  property p_clamp;
    !ctl[CTL_CLAMP_REL] |=> clamp_on_out;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp released early");

  property p_no_key_flags;
    !ctl[CTL_KEY_REPORT] |-> !short_set && !long_set && !rel_set && !err_set;
  endproperty
  a_no_key_flags: assert property (p_no_key_flags) else $error("key flag without report");

  property p_debounce;
    key_state == KEY_DEBOUNCE && !key_press_in |=> key_state == KEY_IDLE && !adc_start_out;
  endproperty
  a_debounce: assert property (p_debounce) else $error("short glitch accepted");

  property p_detach;
    detach_evt |=> mode == MODE_STANDBY && events[EV_DETACH] ##1 signal_switch_out == '0;
  endproperty
  a_detach: assert property (p_detach) else $error("detach not handled");

  property p_auto_to_manual;
    mode == MODE_ACTIVE && $fell(ctl[CTL_AUTO]) && ctl[CTL_GATE]
      |=> sel_manual ##1 signal_switch_out == $past(manual[SW_N-1:0]);
  endproperty
  a_auto_to_manual: assert property (p_auto_to_manual) else $error("manual swap missed");

  property p_audio_set;
    mode == MODE_ACTIVE && ctl[CTL_GATE] && !sel_manual && type_held == DEV_AUDIO1
      |=> signal_switch_out == MASK_AUDIO && !otg_path_switch_out && !vbus_path_switch0_out;
  endproperty
  a_audio_set: assert property (p_audio_set) else $error("audio switch set wrong");

  property p_long_release;
    key_mode && key_state == KEY_LONG && !key_press_in |=> events[EV_LONG_REL] ##1 event_line_out;
  endproperty
  a_long_release: assert property (p_long_release) else $error("long release lost");

  c_attach: cover property (attach_evt ##[1:1000] mode == MODE_ACTIVE);
  c_detach: cover property (mode == MODE_ACTIVE ##1 detach_evt);
  c_short: cover property (short_set && !err_set);
  c_long: cover property (long_set ##[1:1000] rel_set);

endmodule : accessory_switch_key_control

// *** accessory_switch_pkg.sv ***
/*
  Shared constants and types for the accessory switch and key control block.
  Assumes a 125 MHz system clock and byte addresses on the register port.
*/
package accessory_switch_pkg;

  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_TIMING = 8'h04;
  localparam logic [7:0] REG_MANUAL = 8'h08;
  localparam logic [7:0] REG_EVENTS = 8'h0C;
  localparam logic [7:0] REG_BUTTON = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // Control register fields
  localparam int CTL_W = 7;
  localparam int CTL_DELAY_EN = 0;
  localparam int CTL_GATE = 1;
  localparam int CTL_AUTO = 2;
  localparam int CTL_KEY_REPORT = 3;
  localparam int CTL_CLAMP_REL = 4;
  localparam int CTL_OTG_EN = 5;
  localparam int CTL_VBUS_SEL = 6;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 7'h07;

  // Timing register fields, each a 4-bit code
  localparam int TIM_W = 16;
  localparam int TIM_WAIT_LSB = 0;
  localparam int TIM_WAKE_LSB = 4;
  localparam int TIM_SHORT_LSB = 8;
  localparam int TIM_LONG_LSB = 12;
  localparam logic [TIM_W-1:0] TIMING_RESET = 16'h4444;

  // Manual switch register: switches 1..7 in bits 0..6, then jig and boot
  localparam int SW_N = 7;
  localparam int MAN_W = 9;
  localparam int MAN_JIG = 7;
  localparam int MAN_BOOT = 8;
  localparam logic [MAN_W-1:0] MANUAL_RESET = 9'h000;

  // Event flags
  localparam int EV_W = 6;
  localparam int EV_ATTACH = 0;
  localparam int EV_DETACH = 1;
  localparam int EV_SHORT = 2;
  localparam int EV_LONG = 3;
  localparam int EV_LONG_REL = 4;
  localparam int EV_ADC_CHG = 5;

  // Button register
  localparam int BTN_COUNT = 13;
  localparam int BTN_W = 15;
  localparam int BTN_UNKNOWN = 13;
  localparam int BTN_ERROR = 14;
  localparam logic [4:0] BTN_CODE_FIRST = 5'h01;
  localparam int ADC_W = 5;

  // Time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_W = 12;
  localparam logic [MS_W-1:0] DEBOUNCE_MS = 12'h014;
  localparam logic [MS_W-1:0] WAIT_STEP_MS = 12'h064;
  localparam logic [MS_W-1:0] WAKE_STEP_MS = 12'h064;
  localparam logic [MS_W-1:0] SHORT_STEP_MS = 12'h064;
  localparam logic [MS_W-1:0] LONG_STEP_MS = 12'h0FA;

  // Automatic switch sets, switch n in bit n-1
  localparam logic [SW_N-1:0] MASK_NONE = 7'h00;
  localparam logic [SW_N-1:0] MASK_AUDIO = 7'h58;
  localparam logic [SW_N-1:0] MASK_USB = 7'h24;
  localparam logic [SW_N-1:0] MASK_UART = 7'h03;

  typedef enum logic [3:0] {
    DEV_NONE = 4'h0, DEV_USB = 4'h1, DEV_UART = 4'h2, DEV_AUDIO1 = 4'h3,
    DEV_TTY = 4'h4, DEV_USB_CHG = 4'h5, DEV_DED_CHG = 4'h6, DEV_5W1_CHG = 4'h7,
    DEV_5W2_CHG = 4'h8, DEV_JIG_USB = 4'h9, DEV_JIG_UART = 4'hA, DEV_UNKNOWN = 4'hF
  } device_type_type;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00, MODE_HOLD = 2'b01, MODE_ACTIVE = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00, KEY_DEBOUNCE = 2'b01, KEY_HELD = 2'b11, KEY_LONG = 2'b10
  } key_state_type;

endpackage : accessory_switch_pkg

// *** ms_tick_gen.sv ***
/*
  Millisecond enable divider: one-cycle pulse every CYCLES clocks.
  Assumes a single system clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module ms_tick_gen #(
  parameter int unsigned CYCLES = 125000
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Enable pulse
  output logic tick_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] count;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick_out <= 1'b1;
    end else begin
      count <= count + CNT_W'(1);
      tick_out <= 1'b0;
    end
  end

endmodule : ms_tick_gen

// *** accessory_adc_model.sv ***
/*
  Behavioural ID converter and remote-key resistor of an attached headset.
  Assumes the block asks for a conversion with a one-cycle request pulse.
*/
`timescale 1ns/100ps
module accessory_adc_model (
  // Clock
  input wire logic clk_sys_in,
  // Conversion handshake
  input wire logic adc_start_in,
  input wire logic [accessory_switch_pkg::ADC_W-1:0] level_in,
  output logic adc_done_out,
  output logic [accessory_switch_pkg::ADC_W-1:0] adc_result_out
);
  import accessory_switch_pkg::*;
  logic [1:0] busy = 2'h0;
  initial adc_done_out = 1'b0;
  initial adc_result_out = 5'h1F;
  // Result toggles when not valid, so a stale sample never matches by luck
  always @(posedge clk_sys_in) begin
    adc_done_out <= (busy == 2'h1);
    adc_result_out <= (busy == 2'h1) ? level_in : ~adc_result_out;
    if (adc_start_in) begin
      busy <= 2'h3;
    end else if (busy != 2'h0) begin
      busy <= busy - 2'h1;
    end
  end
endmodule : accessory_adc_model

// *** test_accessory_switch_key_control.sv ***
/*
  Self-checking bench for the accessory switch and key control block.
  Assumes a shortened millisecond tick and the converter model beside it.
*/
`timescale 1ns/100ps
module test_accessory_switch_key_control;
  import accessory_switch_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, ev;
  logic wr_s = 1'b0, rd_s = 1'b0, id_done = 1'b0, id_open = 1'b0, key = 1'b0;
  logic adc_done, adc_start, otg, vbus0, vbus1, clamp, jig, boot, ev_line;
  logic [4:0] level = 5'h1F, adc_res;
  logic [6:0] sw;
  device_type_type dev = DEV_NONE;
  int err_count = 0, checks_done = 0, cycles = 0;

  accessory_switch_key_control #(.MS_CYCLES_P(10)) accessory_switch_key_control_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata), .id_done_in(id_done),
    .device_type_in(dev), .id_open_sense_in(id_open), .key_press_in(key),
    .adc_done_in(adc_done), .adc_result_in(adc_res), .adc_start_out(adc_start),
    .signal_switch_out(sw), .otg_path_switch_out(otg), .vbus_path_switch0_out(vbus0),
    .vbus_path_switch1_out(vbus1), .clamp_on_out(clamp), .jig_out(jig), .boot_out(boot),
    .event_line_out(ev_line));
  accessory_adc_model accessory_adc_model_i (.clk_sys_in(clk_sys_in),
    .adc_start_in(adc_start), .level_in(level), .adc_done_out(adc_done),
    .adc_result_out(adc_res));

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Hang guard, well above the expected run
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : wait_cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_sys_in);
    wr_s <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic attach(input device_type_type t);
    @(posedge clk_sys_in);
    id_done <= 1'b1;
    dev <= t;
    @(posedge clk_sys_in);
    id_done <= 1'b0;
  endtask : attach

  task automatic detach;
    @(posedge clk_sys_in);
    id_open <= 1'b1;
    wait_cyc(2100);
    check("switches after detach", 32'(sw), 32'h0);
    rd(REG_EVENTS, ev);
    check("detach flag", ev & 32'h2, 32'h2);
    @(posedge clk_sys_in);
    id_open <= 1'b0;
    wait_cyc(1100);
  endtask : detach

  task automatic press(input logic [4:0] code, input int n);
    @(posedge clk_sys_in);
    key <= 1'b1;
    level <= code;
    wait_cyc(n);
    @(posedge clk_sys_in);
    key <= 1'b0;
    level <= 5'h1F;
    wait_cyc(20);
  endtask : press

  task automatic t_reset;
    rd(REG_CONTROL, ev);
    check("control reset", ev, 32'h07);
    check("clamp at reset", 32'(clamp), 32'h1);
    check("switches at reset", 32'(sw), 32'h0);
    check("event line at reset", 32'(ev_line), 32'h0);
  endtask : t_reset

  task automatic t_delay_and_select;
    wr(REG_TIMING, 32'h0);
    attach(DEV_USB);
    wait_cyc(900);
    check("switches during wait", 32'(sw), 32'h0);
    wait_cyc(250);
    check("usb switches", 32'(sw), 32'(MASK_USB));
    check("usb jig boot", 32'({jig, boot}), 32'h0);
    rd(REG_EVENTS, ev);
    check("attach flag", ev & 32'h1, 32'h1);
    wr(REG_CONTROL, 32'h05);
    wait_cyc(3);
    check("gate low", 32'(sw), 32'h0);
    wr(REG_MANUAL, 32'h1C1);
    wr(REG_CONTROL, 32'h03);
    wait_cyc(3);
    check("manual switches", 32'(sw), 32'h41);
    check("manual jig boot", 32'({jig, boot}), 32'h3);
    wr(REG_CONTROL, 32'h77);
    wait_cyc(3);
    check("back to auto", 32'(sw), 32'h41);
    check("otg follows bit", 32'(otg), 32'h1);
    check("vbus1 follows bit", 32'(vbus1), 32'h1);
    check("clamp released", 32'(clamp), 32'h0);
    detach();
  endtask : t_delay_and_select

  task automatic t_hold;
    wr(REG_CONTROL, 32'h06);
    attach(DEV_UART);
    wait_cyc(1500);
    check("held open", 32'(sw), 32'h0);
    wr(REG_CONTROL, 32'h07);
    wait_cyc(3);
    check("uart switches", 32'(sw), 32'(MASK_UART));
    detach();
  endtask : t_hold

  task automatic t_keys;
    wr(REG_CONTROL, 32'h0F);
    attach(DEV_AUDIO1);
    wait_cyc(1100);
    check("audio switches", 32'(sw), 32'(MASK_AUDIO));
    check("otg isolated", 32'(otg | vbus0), 32'h0);
    rd(REG_EVENTS, ev);
    press(5'h05, 100);
    rd(REG_EVENTS, ev);
    check("glitch ignored", ev & 32'h1C, 32'h0);
    press(5'h05, 400);
    check("event line on release", 32'(ev_line), 32'h1);
    rd(REG_EVENTS, ev);
    check("error press flag", ev & 32'h1C, 32'h04);
    check("event line after read", 32'(ev_line), 32'h0);
    rd(REG_BUTTON, ev);
    check("error bit", ev & 32'h4000, 32'h4000);
    rd(REG_MANUAL, ev);
    check("key conversion result", ev >> 16, 32'h05);
    press(5'h05, 1600);
    rd(REG_EVENTS, ev);
    check("short press flag", ev & 32'h1C, 32'h04);
    rd(REG_BUTTON, ev);
    check("button five", ev, 32'h0010);
    @(posedge clk_sys_in);
    key <= 1'b1;
    level <= 5'h14;
    wait_cyc(3000);
    rd(REG_EVENTS, ev);
    check("long press flag", ev & 32'h1C, 32'h08);
    press(5'h1F, 1);
    rd(REG_EVENTS, ev);
    check("long release flag", ev & 32'h1C, 32'h10);
    rd(REG_BUTTON, ev);
    check("unknown button", ev & 32'h2000, 32'h2000);
  endtask : t_keys

  task automatic t_periodic;
    wr(REG_CONTROL, 32'h07);
    rd(REG_EVENTS, ev);
    press(5'h07, 1600);
    wait_cyc(1100);
    rd(REG_EVENTS, ev);
    check("periodic change only", ev & 32'h3C, 32'h20);
    detach();
  endtask : t_periodic

  initial begin
    wait_cyc(2);
    rst_in <= 1'b0;
    wait_cyc(1);
    t_reset();
    t_delay_and_select();
    t_hold();
    t_keys();
    t_periodic();
    print_verdict();
  end
endmodule : test_accessory_switch_key_control
